//--- logic/dsiae_cmd.sv
/*
 * DSI3 command-and-response decoder for the global node address write and the
 * enter-periodic-mode command, holding the node address and init-done lock.
 * Assumes frames arrive already deserialised, one per rx_valid_i pulse, and that
 * the serialiser sends tx_frame_o when tx_valid_o pulses.
 */
// What this block does
// - Global address write: node 0000, command 1000, node address register, low nibble data.
// - Executed global write loads the low four data bits into the node address.
// - Global write runs and answers only while node address is 0000 and register matches.
// - Write response carries the new node address and echoes command 1000.
// - Write response data: node register low byte, next register high byte.
// - Periodic entry command is code 1011 with sixteen zero data bits plus CRC.
// - Periodic entry to own node address sets lock, enters periodic mode, answers.
// - Periodic entry to global 0000 sets lock and enters mode for any node address.
// - No response is sent for a global periodic entry command.
// - Periodic entry to any other address is ignored: no change, no response.
// - Before entry only command mode; after, periodic mode, diagnostics if enabled.
// - Once locked, protected registers lock and register array verification starts.
// - The init-done lock is sticky; only device reset clears it.
// - Periodic entry response echoes 1011, trim bits in data 11:8, rest zero.
// - Periodic entry response address field holds the current node address.
`timescale 1ns/1ps
`default_nettype none
`include "dsiae_defs.svh"

module dsiae_cmd
	import dsiae_pkg::*;
#(
	parameter logic [7:0] NODE_REG_ADDR = `DSIAE_NODE_ADDR_REG
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic         rx_valid_i,
	input  wire dsiae_frame_t rx_frame_i,
	input  wire logic         diag_mode_enable_i,
	input  wire logic [3:0]   timing_trim_copy_i,
	input  wire logic [7:0]   next_reg_data_i,
	output logic      [3:0]   node_address_o,
	output logic      [7:0]   node_address_register_o,
	output logic              init_done_lock_o,
	output dsiae_modes_t      modes_o,
	output logic              reg_protect_o,
	output logic              array_verify_en_o,
	output logic              crc_error_o,
	output logic              tx_valid_o,
	output dsiae_frame_t      tx_frame_o
);

	// ------------------------------------------------------------------------
	// Frame checking
	// ------------------------------------------------------------------------
	logic [7:0]   rx_crc_calc;
	logic [7:0]   tx_crc_calc;
	logic         crc_ok;
	logic         frame_ok;
	dsiae_frame_t tx_body;

	dsiae_crc8 #(
		.WIDTH (`DSIAE_PAYLOAD_BITS),
		.POLY  (`DSIAE_CRC_POLY),
		.SEED  (`DSIAE_CRC_SEED)
	) u_rx_crc (
		.payload_i (rx_frame_i[31:8]),
		.crc_o     (rx_crc_calc)
	);

	dsiae_crc8 #(
		.WIDTH (`DSIAE_PAYLOAD_BITS),
		.POLY  (`DSIAE_CRC_POLY),
		.SEED  (`DSIAE_CRC_SEED)
	) u_tx_crc (
		.payload_i (tx_body[31:8]),
		.crc_o     (tx_crc_calc)
	);

	assign crc_ok   = (rx_crc_calc == rx_frame_i.crc);
	assign frame_ok = rx_valid_i && crc_ok;

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	// Both commands belong to command-and-response mode, so once periodic
	// mode is on they are left to the periodic decoder and ignored here.
	dsiae_state_t state_reg;
	dsiae_state_t state_next;
	logic [3:0]   node_reg;
	logic [3:0]   node_next;
	logic         in_cmd_mode;
	logic         is_global;
	logic         wr_cmd;
	logic         wr_exec;
	logic         periodic_collection_mode_cmd;
	logic         periodic_collection_mode_global;
	logic         periodic_collection_mode_own;

	assign in_cmd_mode = (state_reg == DSIAE_ST_CMD_RESP);
	assign is_global   = (rx_frame_i.frame_node_field == `DSIAE_GLOBAL_ADDR);

	assign wr_cmd  = frame_ok && in_cmd_mode && is_global
		&& (rx_frame_i.cmd == `DSIAE_CMD_REG_WRITE)
		&& (rx_frame_i.data[15:8] == NODE_REG_ADDR);
	assign wr_exec = wr_cmd && (node_reg == `DSIAE_GLOBAL_ADDR);

	assign periodic_collection_mode_cmd    = frame_ok && in_cmd_mode
		&& (rx_frame_i.cmd == `DSIAE_CMD_ENTER_PERIODIC_COLLECTION_MODE)
		&& (rx_frame_i.data == `DSIAE_PERIODIC_COLLECTION_MODE_CMD_DATA);
	assign periodic_collection_mode_global = periodic_collection_mode_cmd && is_global;
	assign periodic_collection_mode_own    = periodic_collection_mode_cmd && !is_global
		&& (rx_frame_i.frame_node_field == node_reg);

	// ------------------------------------------------------------------------
	// Node address and init-done lock
	// ------------------------------------------------------------------------
	always_comb begin
		node_next  = node_reg;
		state_next = state_reg;
		if (wr_exec) begin
			node_next = rx_frame_i.data[3:0];
		end
		unique case (state_reg)
			DSIAE_ST_CMD_RESP: begin
				if (periodic_collection_mode_global || periodic_collection_mode_own) begin
					state_next = DSIAE_ST_PERIODIC;
				end
			end
			DSIAE_ST_PERIODIC: begin
				state_next = DSIAE_ST_PERIODIC;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			node_reg  <= `DSIAE_NODE_ADDR_RST;
			state_reg <= DSIAE_ST_CMD_RESP;
		end else begin
			node_reg  <= node_next;
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------------
	// Mode outputs
	// ------------------------------------------------------------------------
	always_comb begin
		init_done_lock_o                 = (state_reg == DSIAE_ST_PERIODIC);
		modes_o.crm_active               = !init_done_lock_o;
		modes_o.periodic_collection_mode = init_done_lock_o;
		modes_o.background_diag_mode     = init_done_lock_o && diag_mode_enable_i;
		reg_protect_o                    = init_done_lock_o;
		array_verify_en_o                = init_done_lock_o;
		node_address_o                   = node_reg;
		node_address_register_o          = {`DSIAE_NODE_REG_HI_RST, node_reg};
	end

	// ------------------------------------------------------------------------
	// Response building
	// ------------------------------------------------------------------------
	logic         tx_valid_reg;
	logic         tx_valid_next;
	dsiae_frame_t tx_frame_reg;
	dsiae_frame_t tx_frame_next;
	logic         crc_err_reg;
	logic         crc_err_next;

	always_comb begin
		tx_body = '0;
		if (wr_exec) begin
			tx_body.frame_node_field = rx_frame_i.data[3:0];
			tx_body.cmd              = `DSIAE_CMD_REG_WRITE;
			tx_body.data             = {next_reg_data_i,
				`DSIAE_NODE_REG_HI_RST, rx_frame_i.data[3:0]};
		end else begin
			tx_body.frame_node_field = node_reg;
			tx_body.cmd              = `DSIAE_CMD_ENTER_PERIODIC_COLLECTION_MODE;
			tx_body.data             = {4'h0, timing_trim_copy_i, 8'h00};
		end
	end

	always_comb begin
		tx_valid_next  = wr_exec || periodic_collection_mode_own;
		tx_frame_next  = tx_frame_reg;
		crc_err_next   = rx_valid_i && !crc_ok;
		if (tx_valid_next) begin
			tx_frame_next     = tx_body;
			tx_frame_next.crc = tx_crc_calc;
		end
	end

	// The frame holds after tx_valid_o so a slow serialiser may sample it late.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tx_valid_reg <= 1'b0;
			tx_frame_reg <= '0;
			crc_err_reg  <= 1'b0;
		end else begin
			tx_valid_reg <= tx_valid_next;
			tx_frame_reg <= tx_frame_next;
			crc_err_reg  <= crc_err_next;
		end
	end

	assign tx_valid_o  = tx_valid_reg;
	assign tx_frame_o  = tx_frame_reg;
	assign crc_error_o = crc_err_reg;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// A second divider on the registered frame catches a CRC that was paired
	// with the wrong body, for instance when the body changes after the CRC.
	logic [7:0] resp_crc_calc;

	dsiae_crc8 #(
		.WIDTH (`DSIAE_PAYLOAD_BITS),
		.POLY  (`DSIAE_CRC_POLY),
		.SEED  (`DSIAE_CRC_SEED)
	) u_resp_crc (
		.payload_i (tx_frame_o[31:8]),
		.crc_o     (resp_crc_calc)
	);

	logic rx_periodic_collection_mode_other;
	assign rx_periodic_collection_mode_other = frame_ok && (rx_frame_i.cmd == `DSIAE_CMD_ENTER_PERIODIC_COLLECTION_MODE)
		&& !is_global && (rx_frame_i.frame_node_field != node_reg);

	chk_lock_sticky: assert property (init_done_lock_o |=> init_done_lock_o [*8])
		else $error("init-done lock dropped");

	chk_addr_load: assert property (wr_exec |=> node_address_o == $past(rx_frame_i.data[3:0]))
		else $error("node address not loaded");

	chk_write_guard: assert property (wr_cmd && node_reg != 4'h0 |=> $stable(node_address_o) && !tx_valid_o)
		else $error("global write taken with nonzero node address");

	chk_write_resp: assert property (wr_exec |=> tx_valid_o && tx_frame_o.cmd == 4'h8
		&& tx_frame_o.frame_node_field == node_address_o)
		else $error("write response header wrong");

	chk_write_data: assert property (wr_exec |=> tx_frame_o.data == {$past(next_reg_data_i),
		4'h0, $past(rx_frame_i.data[3:0])})
		else $error("write response data wrong");

	chk_periodic_collection_mode_own: assert property (periodic_collection_mode_own |=> init_done_lock_o && tx_valid_o
		&& tx_frame_o.frame_node_field == $past(node_reg))
		else $error("own periodic entry not answered");

	chk_periodic_collection_mode_global: assert property (periodic_collection_mode_global |=> init_done_lock_o && !tx_valid_o)
		else $error("global periodic entry handled wrongly");

	chk_periodic_collection_mode_ignore: assert property (rx_periodic_collection_mode_other && !init_done_lock_o
		|=> !init_done_lock_o && !tx_valid_o)
		else $error("foreign periodic entry not ignored");

	chk_mode_map: assert property ($rose(init_done_lock_o) |-> !modes_o.crm_active
		&& modes_o.periodic_collection_mode && $past(modes_o.crm_active))
		else $error("mode flags wrong at entry");

	chk_crm_before: assert property (!init_done_lock_o |-> modes_o.crm_active
		&& !modes_o.periodic_collection_mode && !modes_o.background_diag_mode)
		else $error("mode flags wrong before entry");

	chk_diag_follow: assert property (init_done_lock_o |->
		modes_o.background_diag_mode == diag_mode_enable_i)
		else $error("diagnostic mode not following its enable");

	chk_lock_protect: assert property (init_done_lock_o |-> reg_protect_o && array_verify_en_o)
		else $error("protection not on while locked");

	chk_resp_node: assert property (periodic_collection_mode_own |=> tx_frame_o.frame_node_field == node_address_o)
		else $error("periodic entry response node field wrong");

	chk_trim_resp: assert property (periodic_collection_mode_own |=> tx_frame_o.cmd == 4'hB
		&& tx_frame_o.data == {4'h0, $past(timing_trim_copy_i), 8'h00})
		else $error("periodic entry response wrong");

	chk_crc_drop: assert property (rx_valid_i && !crc_ok |=> !tx_valid_o && crc_error_o
		&& $stable(init_done_lock_o) && $stable(node_address_o))
		else $error("bad-CRC frame acted on");

	chk_resp_crc: assert property (tx_valid_o |-> tx_frame_o.crc == resp_crc_calc)
		else $error("response CRC does not match its body");

endmodule : dsiae_cmd
`default_nettype wire

//--- logic/dsiae_crc8.sv
/*
 * Combinational CRC-8 over a frame payload, MSB first.
 * Assumes the caller registers the result where timing matters.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsiae_defs.svh"

module dsiae_crc8
	import dsiae_pkg::*;
#(
	parameter int         WIDTH = `DSIAE_PAYLOAD_BITS,
	parameter logic [7:0] POLY  = `DSIAE_CRC_POLY,
	parameter logic [7:0] SEED  = `DSIAE_CRC_SEED
) (
	input  wire logic [WIDTH-1:0] payload_i,
	output logic      [7:0]       crc_o
);

	// ------------------------------------------------------------------------
	// Bit-serial division unrolled into one combinational pass
	// ------------------------------------------------------------------------
	always_comb begin
		logic [7:0] acc;
		logic       fb;
		acc = SEED;
		fb  = 1'b0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			fb  = acc[7] ^ payload_i[i];
			acc = {acc[6:0], 1'b0};
			if (fb) begin
				acc = acc ^ POLY;
			end
		end
		crc_o = acc;
	end

endmodule : dsiae_crc8
`default_nettype wire

//--- pkg/dsiae_defs.svh
/*
 * Constants of the DSI3 address-assignment and periodic-mode entry decoder:
 * frame codes, the node address register's location, reset values and CRC setup.
 * Assumes it is included by its bare name wherever these values are needed.
 */
`ifndef DSIAE_DEFS_SVH
`define DSIAE_DEFS_SVH

// ----------------------------------------------------------------------------
// Frame field codes
// ----------------------------------------------------------------------------
`define DSIAE_GLOBAL_ADDR      4'h0
`define DSIAE_CMD_REG_WRITE    4'h8
`define DSIAE_CMD_ENTER_PERIODIC_COLLECTION_MODE   4'hB
`define DSIAE_PERIODIC_COLLECTION_MODE_CMD_DATA    16'h0000

// ----------------------------------------------------------------------------
// Register locations and reset values
// ----------------------------------------------------------------------------
`define DSIAE_NODE_ADDR_REG    8'h11
`define DSIAE_NODE_ADDR_RST    4'h0
`define DSIAE_NODE_REG_HI_RST  4'h0

// ----------------------------------------------------------------------------
// Frame CRC: x^8 + x^4 + x^3 + x^2 + 1, seeded with all ones, MSB first
// ----------------------------------------------------------------------------
`define DSIAE_CRC_POLY         8'h1D
`define DSIAE_CRC_SEED         8'hFF
`define DSIAE_PAYLOAD_BITS     24

`endif

//--- pkg/dsiae_pkg.sv
/*
 * Types shared by the DSI3 address-assignment and periodic-mode entry decoder.
 * Assumes dsiae_defs.svh is available on the include path.
 */
`default_nettype none

package dsiae_pkg;

	// ------------------------------------------------------------------------
	// Frame carrier: node field, command, data, CRC, sent MSB first
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  frame_node_field;
		logic [3:0]  cmd;
		logic [15:0] data;
		logic [7:0]  crc;
	} dsiae_frame_t;

	// ------------------------------------------------------------------------
	// Communication mode flags
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic crm_active;
		logic periodic_collection_mode;
		logic background_diag_mode;
	} dsiae_modes_t;

	typedef enum logic {
		DSIAE_ST_CMD_RESP = 1'b0,
		DSIAE_ST_PERIODIC = 1'b1
	} dsiae_state_t;

endpackage : dsiae_pkg
`default_nettype wire

//--- sim/dsiae_cmd_bench.sv
/*
 * Self-checking bench of the decoder against a behavioural model of node address and lock.
 * Assumes the master model drives the frame input and that outputs settle before the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dsiae_cmd_bench;
	import dsiae_pkg::*;
	logic         clk_sys_i;
	logic         rst_i;
	logic         rx_valid_i;
	dsiae_frame_t rx_frame_i;
	logic         diag_mode_enable_i;
	logic [3:0]   timing_trim_copy_i;
	logic [7:0]   next_reg_data_i;
	logic [3:0]   node_address_o;
	logic [7:0]   node_address_register_o;
	logic         init_done_lock_o;
	dsiae_modes_t modes_o;
	logic         reg_protect_o;
	logic         array_verify_en_o;
	logic         crc_error_o;
	logic         tx_valid_o;
	dsiae_frame_t tx_frame_o;
	logic [15:0]  rnd;
	logic [3:0]   m_node;
	logic         m_lock;
	int           n_errors;
	int           cmp_count;
	int           cycles;

	dsiae_cmd u_dsiae_cmd (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
		.diag_mode_enable_i(diag_mode_enable_i), .timing_trim_copy_i(timing_trim_copy_i),
		.next_reg_data_i(next_reg_data_i), .node_address_o(node_address_o),
		.node_address_register_o(node_address_register_o), .init_done_lock_o(init_done_lock_o),
		.modes_o(modes_o), .reg_protect_o(reg_protect_o), .array_verify_en_o(array_verify_en_o),
		.crc_error_o(crc_error_o), .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame_o)
	);

	dsiae_master_model u_dsiae_master_model (
		.clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i)
	);

	// ------------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic final_report;
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic check_state;
		chk("node", node_address_o, m_node);
		chk("node_reg", node_address_register_o, {4'h0, m_node});
		chk("lock", init_done_lock_o, m_lock);
		chk("modes", modes_o, {~m_lock, m_lock, m_lock & diag_mode_enable_i});
		chk("protect", reg_protect_o, m_lock);
		chk("verify", array_verify_en_o, m_lock);
	endtask : check_state

	task automatic do_reset;
		rst_i = 1'b1;
		m_node = 4'h0;
		m_lock = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		rst_i = 1'b0;
	endtask : do_reset

	// The model decides acceptance first, then the frame goes out and the result is compared.
	task automatic step(input logic [3:0] nf, input logic [3:0] cmd, input logic [15:0] data, input logic bad);
		logic        resp;
		logic [31:0] ef;
		resp = 1'b0;
		ef = 32'h0;
		@(negedge clk_sys_i);
		rnd = lfsr(rnd);
		diag_mode_enable_i = rnd[0];
		timing_trim_copy_i = rnd[7:4];
		next_reg_data_i = rnd[15:8];
		if (!bad && !m_lock) begin
			if (cmd == 4'h8 && nf == 4'h0 && m_node == 4'h0 && data[15:8] == 8'h11) begin
				m_node = data[3:0];
				resp = 1'b1;
				ef[31:8] = {m_node, 4'h8, next_reg_data_i, 4'h0, m_node};
			end else if (cmd == 4'hB && data == 16'h0000 && (nf == 4'h0 || nf == m_node)) begin
				m_lock = 1'b1;
				resp = (nf != 4'h0);
				ef[31:8] = {m_node, 4'hB, 4'h0, timing_trim_copy_i, 8'h00};
			end
		end
		u_dsiae_master_model.send(nf, cmd, data, bad);
		ef[7:0] = u_dsiae_master_model.crc8(ef[31:8]);
		chk("tx_valid", tx_valid_o, resp);
		if (resp)
			chk("tx_frame", tx_frame_o, ef);
		chk("crc_error", crc_error_o, bad);
		check_state;
	endtask : step

	// ------------------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			final_report;
		end
	end

	initial begin
		diag_mode_enable_i = 1'b0;
		timing_trim_copy_i = 4'h0;
		next_reg_data_i = 8'h00;
		rnd = 16'hA2DE;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		do_reset;
		check_state;
		step(4'h0, 4'h8, 16'h1203, 1'b0);
		step(4'h0, 4'h8, 16'h1103, 1'b1);
		step(4'h0, 4'h8, {8'h11, rnd[7:1], 1'b1}, 1'b0);
		step(4'h0, 4'h8, 16'h1100, 1'b0);
		step(m_node ^ 4'h2, 4'hB, 16'h0000, 1'b0);
		step(m_node, 4'hB, 16'h0001, 1'b0);
		step(m_node, 4'hB, 16'h0000, 1'b1);
		step(m_node, 4'hB, 16'h0000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			step(4'h0, 4'h8, 16'h1100, 1'b0);
			step(4'h0, 4'hB, 16'h0000, 1'b0);
		end
		do_reset;
		check_state;
		step(4'h0, 4'hB, 16'h0000, 1'b0);
		step(4'h0, 4'h8, 16'h1101, 1'b0);
		final_report;
	end
endmodule : dsiae_cmd_bench

`default_nettype wire

//--- sim/dsiae_master_model.sv
/*
 * Bus master model: builds command frames with their CRC and offers them to the decoder.
 * Assumes send is called just after a falling clock edge; it returns one falling edge later.
 */
`timescale 1ns/1ps
`default_nettype none

module dsiae_master_model
	import dsiae_pkg::*;
(
	input  wire logic    clk_sys_i,
	output logic         rx_valid_o,
	output dsiae_frame_t rx_frame_o
);
	// ------------------------------------------------------------------------
	// Frame building
	// ------------------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [23:0] p);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h1D : 8'h00);
		end
		return c;
	endfunction : crc8

	initial begin
		rx_valid_o = 1'b0;
		rx_frame_o = '0;
	end

	// A released frame bus shows the inverse of the last frame, so no stale value reads as valid.
	task automatic send(input logic [3:0] nf, input logic [3:0] cmd, input logic [15:0] data, input logic bad);
		rx_frame_o = {nf, cmd, data, crc8({nf, cmd, data}) ^ {7'h00, bad}};
		rx_valid_o = 1'b1;
		@(negedge clk_sys_i);
		rx_valid_o = 1'b0;
		rx_frame_o = ~rx_frame_o;
	endtask : send
endmodule : dsiae_master_model

`default_nettype wire
